// [clk_sel_pkg.sv]
// Constants, layouts and helpers shared by the system clock selector.
// What this block does
// [RULE_01] Select code 11 runs the system clock straight from the direct input.
// [RULE_02] Code 10, bypass set: oscillator divided by divider field plus one.
// [RULE_03] Prescaler input is the crystal pin or the internal source.
// [RULE_04] The prescaler divides by any factor up to 1024.
// [RULE_05] Code 10, bypass clear: the loop runs and multiplies the input.
// [RULE_06] Factor is multiplier/(input div*output div), each field plus one.
// [RULE_07] The loop input is either the crystal pin or the internal source.
// [RULE_08] While locking, the loop changes its frequency only gradually; the tuning word steps by one, but the kick moves the step by an eighth at once.
// [RULE_09] Band code 00 picks the lower band, code 01 the higher band.
// [RULE_10] Select code 00 runs the system clock from the wakeup clock.
// [RULE_11] Software stages settings and moves frequency in small steps.
// [RULE_12] Select code 01 is reserved and leaves the source unchanged.
package clk_sel_pkg;

   // Register byte offsets and decoded address width.
   localparam int          ADDR_W      = 8;
   localparam logic [7:0]  SYS_CFG_OFF = 8'h00;
   localparam logic [7:0]  PLL_CFG_OFF = 8'h04;
   localparam logic [7:0]  PRE_CFG_OFF = 8'h08;
   localparam logic [7:0]  STATUS_OFF  = 8'h0c;

   // Clock source select codes.
   localparam logic [1:0] SRC_WAKEUP    = 2'h0;
   localparam logic [1:0] SRC_RESERVED  = 2'h1;
   localparam logic [1:0] SRC_GENERATED = 2'h2;
   localparam logic [1:0] SRC_DIRECT    = 2'h3;

   // VCO band codes.
   localparam logic [1:0] BAND_LOW  = 2'h0;
   localparam logic [1:0] BAND_HIGH = 2'h1;

   // Bus encodings.
   localparam int         HTRANS_ACTIVE_BIT = 1;
   localparam logic [2:0] HSIZE_WORD        = 3'h2;
   localparam logic       HRESP_OKAY        = 1'b0;

   // Loop tuning word range for each band, and widths.
   localparam int          INC_W    = 16;
   localparam int          FACTOR_W = 11;
   localparam int          WEIGHT_W = 12;
   localparam logic [15:0] LO_MIN   = 16'h0100;
   localparam logic [15:0] LO_MAX   = 16'h1000;
   localparam logic [15:0] HI_MIN   = 16'h0800;
   localparam logic [15:0] HI_MAX   = 16'h2000;
   localparam logic [10:0] FACTOR_MAX = 11'h400;

   // Loop damping shift, and the input edges of settled phase for lock.
   localparam int          KICK_SHIFT = 3;
   localparam logic [7:0]  LOCK_EDGES = 8'h40;

   // Register layouts, least significant field last.
   typedef struct packed {
      logic [1:0] clock_source_select;
   } sys_config_s;

   typedef struct packed {
      logic [6:0] pll_output_divider_field;
      logic [7:0] pll_multiplier_field;
      logic [3:0] pll_input_divider_field;
      logic       osc_internal;
      logic [1:0] vco_band_select;
      logic       vco_bypass;
   } pll_config_s;

   typedef struct packed {
      logic [9:0] prescaler_divider_field;
   } pre_config_s;

   typedef struct packed {
      logic [15:0] tuning_word;
      logic        pll_locked;
      logic [1:0]  active_source;
   } status_s;

   localparam sys_config_s SYS_CFG_RESET = '{clock_source_select: SRC_WAKEUP};
   localparam pll_config_s PLL_CFG_RESET = '{vco_bypass: 1'b1, default: '0};
   localparam pre_config_s PRE_CFG_RESET = '{prescaler_divider_field: 10'h000};

   // A divider field holds its factor minus one.
   function automatic logic [10:0] field_factor(input logic [9:0] field);
      return 11'({1'b0, field}) + 11'h001;
   endfunction

endpackage

// [clk_gen_parts.sv]
// Edge-counting divider and the frequency loop used by the clock selector.
module clock_edge_divider #(
   parameter int FACTOR_W = 11
) (
   input  wire logic                ref_clk_in,
   input  wire logic                resetn_in,
   input  wire logic                ce_in,
   input  wire logic                src_level_in,
   input  wire logic [FACTOR_W-1:0] factor_in,
   output logic                     div_out
);
   logic                prev;
   logic [FACTOR_W-1:0] cnt;
   logic [FACTOR_W-1:0] next_cnt;

   // Count rising source edges; the high phase is the first half.
   wire rise = src_level_in & ~prev;
   wire [FACTOR_W-1:0] last = factor_in - FACTOR_W'(1);
   wire pass = (factor_in == FACTOR_W'(1));
   assign next_cnt = !rise ? cnt :
                     (cnt >= last) ? '0 : cnt + FACTOR_W'(1);

   // A factor of one passes the source so its duty cycle survives.
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         prev    <= 1'b0;
         cnt     <= '0;
         div_out <= 1'b0;
      end else if (ce_in) begin
         prev    <= src_level_in;
         cnt     <= next_cnt;
         div_out <= pass ? src_level_in : (next_cnt < (factor_in >> 1)); // [RULE_02]
      end
   end

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   count_bound_a: assert property ( // [RULE_02]
      ce_in && rise && !pass |=> cnt < $past(factor_in))
      else $error("prescaler count reached its factor");
endmodule

module pll_freq_loop #(
   parameter int INC_W    = 16,
   parameter int WEIGHT_W = 12,
   parameter int ERR_W    = 24
) (
   input  wire logic                ref_clk_in,
   input  wire logic                resetn_in,
   input  wire logic                ce_in,
   input  wire logic                enable_in,
   input  wire logic                band_high_in,
   input  wire logic                src_level_in,
   input  wire logic [WEIGHT_W-1:0] mult_weight_in,
   input  wire logic [WEIGHT_W-1:0] div_weight_in,
   output logic                     clk_out,
   output logic                     locked_out,
   output logic [INC_W-1:0]         inc_out
);
   logic                    prev_src;
   logic [INC_W-1:0]        acc;
   logic signed [ERR_W-1:0] err;
   logic signed [ERR_W-1:0] next_err;
   logic [INC_W-1:0]        next_inc;
   logic [7:0]              lock_cnt;
   logic [7:0]              next_lock;

   // Band limits on the tuning word.
   wire [INC_W-1:0] inc_min = band_high_in ? INC_W'(clk_sel_pkg::HI_MIN)
                                           : INC_W'(clk_sel_pkg::LO_MIN);
   wire [INC_W-1:0] inc_max = band_high_in ? INC_W'(clk_sel_pkg::HI_MAX)
                                           : INC_W'(clk_sel_pkg::LO_MAX);
   // A phase kick on the accumulator step damps the loop, at the cost of
   // some jitter; the tuning word still moves one step per input edge.
   wire [INC_W-1:0] kick     = inc_out >> clk_sel_pkg::KICK_SHIFT;
   wire [INC_W-1:0] acc_step = (err > 0) ? inc_out + kick :
                               (err < 0) ? inc_out - kick : inc_out;
   wire [INC_W-1:0] acc_sum  = acc + acc_step;
   wire             in_rise  = src_level_in & ~prev_src;
   wire             out_rise = acc_sum[INC_W-1] & ~clk_out;

   // Input edges weigh the multiplier, output edges the product of both
   // dividers, so the phase error settles when fout is fin times the factor.
   wire signed [ERR_W-1:0] add_w = in_rise ?
        ERR_W'({1'b0, mult_weight_in}) : '0; // [RULE_06]
   wire signed [ERR_W-1:0] sub_w = out_rise ?
        ERR_W'({1'b0, div_weight_in}) : '0; // [RULE_06]
   assign next_err = err + add_w - sub_w;
   wire signed [ERR_W-1:0] win = ERR_W'({1'b0, mult_weight_in})
                               + ERR_W'({1'b0, div_weight_in});
   wire signed [ERR_W-1:0] mag = err[ERR_W-1] ? -err : err;

   // Lock needs the phase error inside its window for a run of input
   // edges; one zero crossing of a swinging loop is not lock.
   wire in_win    = (mag <= win);
   wire lock_full = (lock_cnt == clk_sel_pkg::LOCK_EDGES);
   assign next_lock = !in_win ? '0 :
                      (in_rise && !lock_full) ? lock_cnt + 8'h01 : lock_cnt;

   // One step per input edge: the tuning word never jumps.
   assign next_inc = !in_rise ? inc_out :
      (inc_out < inc_min) ? inc_out + INC_W'(1) :
      (inc_out > inc_max) ? inc_out - INC_W'(1) :
      (err > 0 && inc_out < inc_max) ? inc_out + INC_W'(1) :
      (err < 0 && inc_out > inc_min) ? inc_out - INC_W'(1) : inc_out; // [RULE_08]

   // Disabled loop restarts low in the selected band.
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         prev_src   <= 1'b0;
         acc        <= '0;
         clk_out    <= 1'b0;
         err        <= '0;
         lock_cnt   <= '0;
         locked_out <= 1'b0;
         inc_out    <= INC_W'(clk_sel_pkg::LO_MIN);
      end else if (ce_in) begin
         prev_src   <= src_level_in;
         acc        <= enable_in ? acc_sum : '0;
         clk_out    <= enable_in & acc_sum[INC_W-1];
         err        <= enable_in ? next_err : '0;
         lock_cnt   <= enable_in ? next_lock : '0;
         locked_out <= enable_in && in_win && lock_full;
         inc_out    <= enable_in ? next_inc : inc_min; // [RULE_09]
      end
   end

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   gradual_step_a: assert property ( // [RULE_08]
      ce_in && enable_in && $past(enable_in) |->
      inc_out == $past(inc_out) ||
      inc_out == $past(inc_out) + INC_W'(1) ||
      inc_out == $past(inc_out) - INC_W'(1))
      else $error("tuning word jumped");

   band_climb_a: assert property ( // [RULE_09]
      ce_in && enable_in && band_high_in && in_rise &&
      inc_out < INC_W'(clk_sel_pkg::HI_MIN)
      |=> inc_out == $past(inc_out) + INC_W'(1))
      else $error("high band not approached");

   weight_pair_a: assert property ( // [RULE_06]
      ce_in && enable_in && in_rise && !out_rise
      |=> err == $past(err) + ERR_W'({1'b0, $past(mult_weight_in)}))
      else $error("input edge weight wrong");
endmodule

// [system_clock_source_select.sv]
// System clock source selector with its AHB-Lite register slave.
module system_clock_source_select (
   input  wire logic        ref_clk_in,
   input  wire logic        resetn_in,
   input  wire logic        ce_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   input  wire logic        direct_clock_input_in,
   input  wire logic        crystal_input_in,
   input  wire logic        internal_clock_in,
   input  wire logic        wakeup_clock_in,
   output logic [31:0]      hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   output logic             sys_clock_out,
   output logic             pll_enable_out
);

   // Configuration and bus state.
   clk_sel_pkg::sys_config_s sys_cfg;
   clk_sel_pkg::pll_config_s pll_cfg;
   clk_sel_pkg::pre_config_s pre_cfg;
   clk_sel_pkg::status_s     status;
   logic                     wr_pend;
   logic                     rd_pend;
   logic [clk_sel_pkg::ADDR_W-1:0] xfer_addr;

   // Clock paths.
   logic                                presc_clk;
   logic                                pll_clk;
   logic                                pll_locked;
   logic [clk_sel_pkg::INC_W-1:0]       pll_inc;
   logic                                next_sys;
   logic [31:0]                         rd_word;

   // Address phase decode. Only whole-word writes are stored; a
   // narrower write completes OKAY but leaves the registers alone.
   wire take = hsel_in && hready_in
             && htrans_in[clk_sel_pkg::HTRANS_ACTIVE_BIT];
   wire take_wr = take && hwrite_in
                && (hsize_in == clk_sel_pkg::HSIZE_WORD);
   wire take_rd = take && !hwrite_in;

   // Data phase write strobes.
   wire wr_sys = wr_pend && (xfer_addr == clk_sel_pkg::SYS_CFG_OFF);
   wire wr_pll = wr_pend && (xfer_addr == clk_sel_pkg::PLL_CFG_OFF);
   wire wr_pre = wr_pend && (xfer_addr == clk_sel_pkg::PRE_CFG_OFF);

   // Incoming register images.
   wire clk_sel_pkg::sys_config_s wr_sys_val =
      clk_sel_pkg::sys_config_s'(hwdata_in[1:0]);
   wire clk_sel_pkg::pll_config_s wr_pll_val =
      clk_sel_pkg::pll_config_s'(hwdata_in[22:0]);
   wire clk_sel_pkg::pre_config_s wr_pre_val =
      clk_sel_pkg::pre_config_s'(hwdata_in[9:0]);

   // The reserved select code is dropped so the running source
   // stays put instead of falling into an undefined path.
   wire sel_reserved = (wr_sys_val.clock_source_select
                        == clk_sel_pkg::SRC_RESERVED); // [RULE_12]
   wire sys_load = wr_sys && !sel_reserved; // [RULE_12]

   // Decoded controls.
   wire [1:0] src_sel     = sys_cfg.clock_source_select;
   wire       is_direct   = (src_sel == clk_sel_pkg::SRC_DIRECT);
   wire       is_gen      = (src_sel == clk_sel_pkg::SRC_GENERATED);
   wire       bypass      = pll_cfg.vco_bypass;
   wire       pll_run     = is_gen && !bypass; // [RULE_05]
   wire       band_high   = (pll_cfg.vco_band_select
                             == clk_sel_pkg::BAND_HIGH); // [RULE_09]

   // Oscillator choice feeds both the prescaler and the loop.
   wire osc_level = pll_cfg.osc_internal ? internal_clock_in
                                         : crystal_input_in; // [RULE_03]

   // Divider factors, each field plus one.
   wire [clk_sel_pkg::FACTOR_W-1:0] presc_factor = clk_sel_pkg::field_factor(
      pre_cfg.prescaler_divider_field); // [RULE_04]
   wire [clk_sel_pkg::FACTOR_W-1:0] p_factor = clk_sel_pkg::field_factor(
      10'(pll_cfg.pll_input_divider_field)); // [RULE_06]
   wire [clk_sel_pkg::FACTOR_W-1:0] n_factor = clk_sel_pkg::field_factor(
      10'(pll_cfg.pll_multiplier_field)); // [RULE_06]
   wire [clk_sel_pkg::FACTOR_W-1:0] outdiv_factor = clk_sel_pkg::field_factor(
      10'(pll_cfg.pll_output_divider_field)); // [RULE_06]

   // Input times output divider is at most 16 times 128, inside the weight.
   wire [2*clk_sel_pkg::FACTOR_W-1:0] pk2_full = p_factor * outdiv_factor;
   wire [clk_sel_pkg::WEIGHT_W-1:0] div_weight =
      pk2_full[clk_sel_pkg::WEIGHT_W-1:0]; // [RULE_06]
   wire [clk_sel_pkg::WEIGHT_W-1:0] mult_weight =
      clk_sel_pkg::WEIGHT_W'(n_factor); // [RULE_06]

   // Output prescaler on the oscillator clock.
   clock_edge_divider #(
      .FACTOR_W (clk_sel_pkg::FACTOR_W)
   ) u_prescaler (
      .ref_clk_in   (ref_clk_in),
      .resetn_in    (resetn_in),
      .ce_in        (ce_in),
      .src_level_in (osc_level),
      .factor_in    (presc_factor),
      .div_out      (presc_clk)
   );

   // Frequency loop; it only runs while selected, so it starts its
   // approach from the bottom of the band in force in its last disabled cycle.
   pll_freq_loop #(
      .INC_W    (clk_sel_pkg::INC_W),
      .WEIGHT_W (clk_sel_pkg::WEIGHT_W)
   ) u_pll (
      .ref_clk_in     (ref_clk_in),
      .resetn_in      (resetn_in),
      .ce_in          (ce_in),
      .enable_in      (pll_run),
      .band_high_in   (band_high),
      .src_level_in   (osc_level),
      .mult_weight_in (mult_weight),
      .div_weight_in  (div_weight),
      .clk_out        (pll_clk),
      .locked_out     (pll_locked),
      .inc_out        (pll_inc)
   );

   // System clock source mux; the reserved code never reaches here.
   assign next_sys = is_direct ? direct_clock_input_in :        // [RULE_01]
                     !is_gen   ? wakeup_clock_in :              // [RULE_10]
                     bypass    ? presc_clk :                    // [RULE_02]
                                 pll_clk;                       // [RULE_05]

   // Status image shows the running source and the loop state.
   assign status = '{tuning_word:   pll_inc,
                     pll_locked:    pll_locked,
                     active_source: src_sel};

   // Read mux; unmapped offsets read as zero.
   assign rd_word =
      (xfer_addr == clk_sel_pkg::SYS_CFG_OFF) ? 32'(sys_cfg) :
      (xfer_addr == clk_sel_pkg::PLL_CFG_OFF) ? 32'(pll_cfg) :
      (xfer_addr == clk_sel_pkg::PRE_CFG_OFF) ? 32'(pre_cfg) :
      (xfer_addr == clk_sel_pkg::STATUS_OFF)  ? 32'(status)  :
                                                32'h0000_0000;

   // Bus handshake. Reads take one wait state so that a write in
   // the previous data phase is always visible to the read.
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_pend       <= 1'b0;
         rd_pend       <= 1'b0;
         xfer_addr     <= '0;
         hreadyout_out <= 1'b1;
         hresp_out     <= clk_sel_pkg::HRESP_OKAY;
         hrdata_out    <= 32'h0000_0000;
      end else if (ce_in) begin
         wr_pend       <= take_wr;
         rd_pend       <= take_rd;
         hreadyout_out <= !take_rd;
         hresp_out     <= clk_sel_pkg::HRESP_OKAY;
         if (take) begin
            xfer_addr <= haddr_in[clk_sel_pkg::ADDR_W-1:0];
         end
         if (rd_pend) begin
            hrdata_out <= rd_word;
         end
      end
   end

   // Configuration registers. Software must stage changes so that
   // no unintended intermediate setting runs the clock.
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sys_cfg <= clk_sel_pkg::SYS_CFG_RESET;
         pll_cfg <= clk_sel_pkg::PLL_CFG_RESET;
         pre_cfg <= clk_sel_pkg::PRE_CFG_RESET;
      end else if (ce_in) begin
         if (sys_load) begin
            sys_cfg <= wr_sys_val; // [RULE_12]
         end
         if (wr_pll) begin
            pll_cfg <= wr_pll_val; // [RULE_07]
         end
         if (wr_pre) begin
            pre_cfg <= wr_pre_val;
         end
      end
   end

   // Outputs are registered so the system clock never glitches on
   // a combinational hazard in the mux.
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sys_clock_out  <= 1'b0;
         pll_enable_out <= 1'b0;
      end else if (ce_in) begin
         sys_clock_out  <= next_sys;
         pll_enable_out <= pll_run; // [RULE_05]
      end
   end

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   direct_drive_a: assert property ( // [RULE_01]
      ce_in && is_direct
      |=> sys_clock_out == $past(direct_clock_input_in))
      else $error("direct drive does not follow its input");

   prescale_path_a: assert property ( // [RULE_02]
      ce_in && is_gen && bypass
      |=> sys_clock_out == $past(presc_clk))
      else $error("prescaler path not selected");

   osc_input_a: assert property ( // [RULE_03]
      ce_in && pll_cfg.osc_internal && $past(ce_in)
      |-> osc_level == internal_clock_in)
      else $error("oscillator input choice wrong");

   presc_range_a: assert property ( // [RULE_04]
      presc_factor <= clk_sel_pkg::FACTOR_MAX &&
      presc_factor == 11'({1'b0, pre_cfg.prescaler_divider_field}) + 11'h001)
      else $error("prescaler factor out of range");

   pll_path_a: assert property ( // [RULE_05]
      ce_in && is_gen && !bypass
      |=> pll_enable_out && sys_clock_out == $past(pll_clk))
      else $error("loop path not selected");

   loop_input_a: assert property ( // [RULE_07]
      ce_in && wr_pll |=> pll_cfg.osc_internal == $past(hwdata_in[3]))
      else $error("loop input choice not stored");

   wakeup_path_a: assert property ( // [RULE_10]
      ce_in && src_sel == clk_sel_pkg::SRC_WAKEUP
      |=> sys_clock_out == $past(wakeup_clock_in) && !pll_enable_out)
      else $error("wakeup clock not selected");

   reserved_code_a: assert property ( // [RULE_12]
      ce_in && wr_sys && sel_reserved
      |=> sys_cfg == $past(sys_cfg))
      else $error("reserved select code changed the source");

   read_wait_a: assert property (
      ce_in && take_rd |=> !hreadyout_out ##1 hreadyout_out)
      else $error("read wait state missing");

   direct_mode_c:  cover property (ce_in && is_direct);
   prescale_mode_c: cover property (ce_in && is_gen && bypass);
   pll_lock_c:     cover property (pll_run && pll_locked);
   reserved_wr_c:  cover property (ce_in && wr_sys && sel_reserved);

endmodule

// [clk_src_model.sv]
// Free-running clock sources at the far side of the selector.
module clk_src_model #(
   parameter int XTAL_HALF = 8,
   parameter int INT_HALF  = 5,
   parameter int DIR_HALF  = 3,
   parameter int WU_HALF   = 20
) (
   input  wire logic ref_clk_in,
   output logic      crystal_out,
   output logic      internal_out,
   output logic      direct_out,
   output logic      wakeup_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF [4] = '{XTAL_HALF, INT_HALF, DIR_HALF, WU_HALF};
   int         cnt [4] = '{default: 0};
   logic [3:0] lvl = 4'h0;
   // Oscillators run freely; distinct periods keep the sources apart.
   always_ff @(posedge ref_clk_in) begin
      for (int i = 0; i < 4; i++) begin
         cnt[i] <= (cnt[i] == HALF[i] - 1) ? 0 : cnt[i] + 1;
         lvl[i] <= (cnt[i] == HALF[i] - 1) ? ~lvl[i] : lvl[i];
      end
   end
   // Level outputs of each source.
   assign crystal_out  = lvl[0];
   assign internal_out = lvl[1];
   assign direct_out   = lvl[2];
   assign wakeup_out   = lvl[3];
endmodule

// [system_clock_source_select_tb.sv]
// Self-checking bench for the system clock source selector.
module system_clock_source_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int XH = 8;
   localparam int IH = 5;
   localparam int EXP_LO = 1024 / (2 * XH) / 8;
   localparam int EXP_HI = 2000 / (2 * IH) * 7 / 20;
   logic        ref_clk_in = 1'b0;
   logic        resetn_in  = 1'b0;
   logic        hsel_in    = 1'b0;
   logic [31:0] haddr_in   = '0;
   logic [1:0]  htrans_in  = 2'h0;
   logic        hwrite_in  = 1'b0;
   logic [2:0]  hsize_in   = 3'h2;
   logic [31:0] hwdata_in  = '0;
   logic [31:0] hrdata_out;
   logic        hready, hresp_out, sys_clock_out, pll_enable_out;
   logic        xtal, intc, dirc, wuc, prev_dir, prev_wu;
   logic [15:0] tw;
   int          err_total = 0;
   int          compares  = 0;
   int          n;

   // Free-running 200 MHz clock.
   always #2.5 ref_clk_in = ~ref_clk_in;
   // Source levels one cycle back, which the selected output must repeat.
   always @(posedge ref_clk_in) begin
      prev_dir <= dirc;
      prev_wu  <= wuc;
   end

   system_clock_source_select system_clock_source_select_inst (
      .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .ce_in(1'b1),
      .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
      .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
      .hready_in(hready), .direct_clock_input_in(dirc),
      .crystal_input_in(xtal), .internal_clock_in(intc),
      .wakeup_clock_in(wuc), .hrdata_out(hrdata_out),
      .hreadyout_out(hready), .hresp_out(hresp_out),
      .sys_clock_out(sys_clock_out), .pll_enable_out(pll_enable_out));

   clk_src_model #(.XTAL_HALF(XH), .INT_HALF(IH)) clk_src_model_inst (
      .ref_clk_in(ref_clk_in), .crystal_out(xtal), .internal_out(intc),
      .direct_out(dirc), .wakeup_out(wuc));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One single AHB-Lite transfer; waits on hready in both phases.
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      haddr_in  <= {24'h0, a};
      hwrite_in <= wr;
      htrans_in <= 2'h2;
      hsel_in   <= 1'b1;
      do @(posedge ref_clk_in); while (hready !== 1'b1);
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      do @(posedge ref_clk_in); while (hready !== 1'b1);
      rd = hrdata_out;
      check(32'(hresp_out), 32'h0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      check(x, exp);
   endtask

   // Loop word from factors: output divider, multiplier, input divider.
   function automatic logic [31:0] pllw(input int k2, input int m,
      input int p, input logic osc, input logic [1:0] bd, input logic byp);
      return {9'h0, 7'(k2 - 1), 8'(m - 1), 4'(p - 1), osc, bd, byp};
   endfunction

   // The output must repeat the chosen source one cycle late.
   task automatic follow(input logic sel_dir, input int cyc);
      @(posedge ref_clk_in);
      repeat (cyc) begin
         @(posedge ref_clk_in);
         #1;
         check(32'(sys_clock_out), 32'(sel_dir ? prev_dir : prev_wu));
      end
   endtask

   // Source rising edges within the second full output period.
   task automatic ratio(input logic use_int, output int k);
      logic ps, pc, s, c;
      int   st;
      k  = 0;
      st = 0;
      ps = 1'b1;
      pc = 1'b1;
      for (int i = 0; i < 40000 && st < 3; i++) begin
         @(posedge ref_clk_in);
         s = sys_clock_out;
         c = use_int ? intc : xtal;
         if (c && !pc && st == 2) k++;
         if (s && !ps) st++;
         ps = s;
         pc = c;
      end
   endtask

   task automatic edges(input int cyc, output int k);
      logic ps;
      k  = 0;
      ps = sys_clock_out;
      repeat (cyc) begin
         @(posedge ref_clk_in);
         if (sys_clock_out && !ps) k++;
         ps = sys_clock_out;
      end
   endtask

   // Polls status until lock; the tuning word may move one step per poll.
   task automatic lock_wait(output logic [15:0] w);
      logic [31:0] st;
      logic [15:0] last;
      logic        ok;
      ok = 1'b1;
      bus(1'b0, clk_sel_pkg::STATUS_OFF, 32'h0, st);
      last = st[18:3];
      for (int i = 0; i < 8000 && st[2] !== 1'b1; i++) begin
         bus(1'b0, clk_sel_pkg::STATUS_OFF, 32'h0, st);
         if (st[18:3] > last + 1 || last > st[18:3] + 1) ok = 1'b0;
         last = st[18:3];
      end
      check(32'(ok), 32'h1);
      check(32'(st[2]), 32'h1);
      w = st[18:3];
   endtask

   task automatic tally_and_finish;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Cuts a hang short well above the expected run of some 45k cycles.
   initial begin
      #450000;
      err_total++;
      tally_and_finish();
   end

   initial begin
      repeat (16) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      @(posedge ref_clk_in);
      rdc(clk_sel_pkg::SYS_CFG_OFF, 32'h0);
      rdc(clk_sel_pkg::PLL_CFG_OFF, 32'h1);
      rdc(clk_sel_pkg::PRE_CFG_OFF, 32'h0);
      rdc(8'h40, 32'h0);
      follow(1'b0, 60);
      wr(clk_sel_pkg::SYS_CFG_OFF, 32'h3);
      follow(1'b1, 30);
      wr(clk_sel_pkg::SYS_CFG_OFF, 32'h1);
      rdc(clk_sel_pkg::SYS_CFG_OFF, 32'h3);
      follow(1'b1, 20);
      hsize_in <= 3'h0;
      wr(clk_sel_pkg::PRE_CFG_OFF, 32'h5);
      hsize_in <= 3'h2;
      rdc(clk_sel_pkg::PRE_CFG_OFF, 32'h0);
      // Prescaler from the crystal, then from the internal source.
      wr(clk_sel_pkg::PRE_CFG_OFF, 32'h3);
      wr(clk_sel_pkg::PLL_CFG_OFF, pllw(1, 1, 1, 1'b0, 2'h0, 1'b1));
      wr(clk_sel_pkg::SYS_CFG_OFF, 32'h2);
      ratio(1'b0, n);
      check(32'(n), 32'd4);
      check(32'(pll_enable_out), 32'h0);
      wr(clk_sel_pkg::PLL_CFG_OFF, pllw(1, 1, 1, 1'b1, 2'h0, 1'b1));
      ratio(1'b1, n);
      check(32'(n), 32'd4);
      wr(clk_sel_pkg::PRE_CFG_OFF, 32'h3ff);
      ratio(1'b1, n);
      check(32'(n), 32'd1024);
      // Loop settings are staged with bypass set, then enabled.
      wr(clk_sel_pkg::PLL_CFG_OFF, pllw(2, 1, 4, 1'b0, 2'h0, 1'b1));
      wr(clk_sel_pkg::PLL_CFG_OFF, pllw(2, 1, 4, 1'b0, 2'h0, 1'b0));
      repeat (2) @(posedge ref_clk_in);
      check(32'(pll_enable_out), 32'h1);
      lock_wait(tw);
      check(32'(tw <= clk_sel_pkg::LO_MAX), 32'h1);
      edges(1024, n);
      check(32'(n >= EXP_LO - 1 && n <= EXP_LO + 1), 32'h1);
      wr(clk_sel_pkg::PLL_CFG_OFF, pllw(5, 7, 4, 1'b1, 2'h1, 1'b1));
      wr(clk_sel_pkg::PLL_CFG_OFF, pllw(5, 7, 4, 1'b1, 2'h1, 1'b0));
      lock_wait(tw);
      check(32'(tw >= clk_sel_pkg::HI_MIN), 32'h1);
      edges(2000, n);
      check(32'(n >= EXP_HI - 3 && n <= EXP_HI + 3), 32'h1);
      wr(clk_sel_pkg::SYS_CFG_OFF, 32'h3);
      repeat (2) @(posedge ref_clk_in);
      check(32'(pll_enable_out), 32'h0);
      tally_and_finish();
   end
endmodule
